// ===== hw/pss_pkg.sv
package pss_pkg;
    // Mode encodings
    localparam logic [1:0] CYC_SINGLE = 2'h0;
    localparam logic [1:0] CYC_CONT = 2'h1;
    localparam logic [1:0] CYC_HOLD = 2'h2;
    localparam logic UNIT_SEC = 1'h0;
    localparam logic UNIT_MIN = 1'h1;
    localparam logic [1:0] REC_OFF = 2'h0;
    // Stage geometry
    localparam int NUM_STAGES = 15;
    localparam int IDX_W = 4;
    localparam int DUR_W = 16;
    localparam logic [15:0] DUR_MAX = 16'h8CA0;
    localparam int MODE_DIR_BIT = 2;
    // Timing
    localparam int CLK_HZ = 100000000;
    localparam int TENTH_SEC_CYC = CLK_HZ / 10;
    localparam int TENTHS_PER_MIN_TICK = 60;
    localparam int PULSE_MS = 250;
    localparam int PULSE_CYC = (CLK_HZ / 1000) * PULSE_MS;

    typedef enum logic [1:0] {
        PSS_IDLE = 2'b00,
        PSS_RUN = 2'b01,
        PSS_PAUSE = 2'b11,
        PSS_HOLD = 2'b10
    } pss_state_t;
endpackage : pss_pkg

// ===== hw/pss_pulse_if.sv
`timescale 1ns/10ps
interface pss_pulse_if;
    logic fire;
    logic active;
    modport src (output fire, input active);
    modport gen (input fire, output active);
endinterface : pss_pulse_if

// ===== hw/pss_pulse.sv
`timescale 1ns/10ps
module pss_pulse #(
    parameter int LEN = 25000000
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    pss_pulse_if.gen pif
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic act_reg;
    logic act_next;

    if (LEN < 1) begin : g_bad_len
        $error("LEN must be positive");
    end

    always_comb begin
        cnt_next = cnt_reg;
        act_next = act_reg;
        if (pif.fire) begin
            cnt_next = 32'(LEN - 1);
            act_next = 1'b1;
        end else if (cnt_reg != 32'h0) begin
            cnt_next = cnt_reg - 32'h1;
        end else begin
            act_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cnt_reg <= 32'h0;
            act_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            act_reg <= act_next;
        end
    end

    assign pif.active = act_reg;
endmodule : pss_pulse

// ===== hw/pss_sequencer.sv
`timescale 1ns/10ps
// Behaviour
// - Mode 0 runs once then stops.
// - Mode 1 wraps to first stage forever.
// - Mode 2 holds last nonzero-frequency stage.
// - Unit 0 seconds, 1 minutes.
// - Fifteen stage durations, 0 to 3600.0.
// - Run mode code gives direction, acc set.
// - Record off: stop restarts at stage one.
// - Record on: stop pauses, run resumes; a stop in hold goes idle.
// - Rewriting cycle mode while stopped clears progress.
// - Stage end gives 250 ms pulse.
// - Cycle end gives 250 ms pulse.
module pss_sequencer #(
    parameter int TENTH_CYC = pss_pkg::TENTH_SEC_CYC,
    parameter int PULSE_LEN = pss_pkg::PULSE_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Settings
    input wire logic [1:0] cycle_mode_select_in,
    input wire logic cycle_mode_write_in,
    input wire logic stage_time_unit_in,
    input wire logic [1:0] record_mode_in,
    input wire logic [15*16-1:0] stage_duration_set_in,
    input wire logic [15*3-1:0] stage_run_mode_set_in,
    input wire logic [14:0] stage_freq_nonzero_in,
    // Run command
    input wire logic run_cmd_in,
    // Outputs
    output logic run_out,
    output logic [3:0] stage_index_out,
    output logic reverse_out,
    output logic [1:0] acc_set_out,
    output logic stage_end_out,
    output logic cycle_end_out
);
    localparam int N = pss_pkg::NUM_STAGES;

    if (TENTH_CYC < 1 || PULSE_LEN < 1) begin : g_bad_timing
        $error("Bad timing parameter");
    end

    function automatic logic [15:0] dur_of(input logic [3:0] i);
        logic [15:0] d;
        d = stage_duration_set_in[i*16 +: 16];
        if (d > pss_pkg::DUR_MAX) d = pss_pkg::DUR_MAX;
        return d;
    endfunction : dur_of

    function automatic logic [2:0] mode_of(input logic [3:0] i);
        return stage_run_mode_set_in[i*3 +: 3];
    endfunction : mode_of

    pss_pkg::pss_state_t st_reg, st_next;
    logic [3:0] idx_reg, idx_next, hold_reg, hold_next;
    logic [15:0] el_reg, el_next;
    logic [31:0] pre_reg, pre_next;
    logic [5:0] min_reg, min_next;
    logic run_reg, run_next, rev_reg, rev_next, done_reg, done_next;
    logic [1:0] acc_reg, acc_next;
    logic tick, stage_done, last_stage;
    logic [3:0] out_idx;

    pss_pulse_if se_if ();
    pss_pulse_if ce_if ();
    pss_pulse #(.LEN(PULSE_LEN)) u_se (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .pif(se_if)
    );
    pss_pulse #(.LEN(PULSE_LEN)) u_ce (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .pif(ce_if)
    );

    always_comb begin
        pre_next = pre_reg;
        min_next = min_reg;
        tick = 1'b0;
        if (st_reg == pss_pkg::PSS_IDLE) begin
            pre_next = 32'h0; // Fresh tick phase for stage one
            min_next = 6'h0;
        end else if (st_reg != pss_pkg::PSS_RUN) begin
            pre_next = pre_reg;
        end else if (pre_reg == 32'(TENTH_CYC - 1)) begin
            pre_next = 32'h0;
            // Minute mode: sixty tenth-seconds per tick
            if (stage_time_unit_in == pss_pkg::UNIT_SEC) begin
                tick = 1'b1;
            end else if (min_reg == 6'(pss_pkg::TENTHS_PER_MIN_TICK - 1)) begin
                min_next = 6'h0;
                tick = 1'b1;
            end else begin
                min_next = min_reg + 6'h1;
            end
        end else begin
            pre_next = pre_reg + 32'h1;
        end
        // Duration reached ends the stage
        stage_done = (st_reg == pss_pkg::PSS_RUN) && (el_reg >= dur_of(idx_reg));
        last_stage = (idx_reg == 4'(N - 1));
    end

    always_comb begin
        st_next = st_reg;
        idx_next = idx_reg;
        el_next = el_reg;
        hold_next = hold_reg;
        done_next = done_reg && run_cmd_in;
        se_if.fire = 1'b0;
        ce_if.fire = 1'b0;
        case (st_reg)
            pss_pkg::PSS_IDLE: begin
                if (run_cmd_in && !done_reg) st_next = pss_pkg::PSS_RUN;
            end
            pss_pkg::PSS_RUN: begin
                if (!run_cmd_in) begin
                    if (record_mode_in == pss_pkg::REC_OFF) begin
                        st_next = pss_pkg::PSS_IDLE;
                        idx_next = 4'h0;
                        el_next = 16'h0;
                    end else begin
                        st_next = pss_pkg::PSS_PAUSE;
                    end
                end else if (stage_done) begin
                    se_if.fire = 1'b1;
                    el_next = 16'h0;
                    if (stage_freq_nonzero_in[idx_reg]) hold_next = idx_reg;
                    if (!last_stage) begin
                        idx_next = idx_reg + 4'h1;
                    end else begin
                        ce_if.fire = 1'b1;
                        idx_next = 4'h0;
                        case (cycle_mode_select_in)
                            pss_pkg::CYC_CONT: st_next = pss_pkg::PSS_RUN;
                            pss_pkg::CYC_HOLD: st_next = pss_pkg::PSS_HOLD;
                            default: begin
                                st_next = pss_pkg::PSS_IDLE;
                                done_next = 1'b1;
                            end
                        endcase
                    end
                end else if (tick) begin
                    el_next = el_reg + 16'h1;
                end
            end
            pss_pkg::PSS_PAUSE: begin
                if (cycle_mode_write_in) begin
                    st_next = pss_pkg::PSS_IDLE;
                    idx_next = 4'h0;
                    el_next = 16'h0;
                end else if (run_cmd_in) begin
                    st_next = pss_pkg::PSS_RUN;
                end
            end
            pss_pkg::PSS_HOLD: begin
                if (!run_cmd_in) st_next = pss_pkg::PSS_IDLE;
            end
            default: st_next = pss_pkg::PSS_IDLE;
        endcase
        if (st_reg == pss_pkg::PSS_IDLE && cycle_mode_write_in) begin
            idx_next = 4'h0;
            el_next = 16'h0;
        end
    end

    always_comb begin
        out_idx = (st_next == pss_pkg::PSS_HOLD) ? hold_next : idx_next;
        run_next = (st_next == pss_pkg::PSS_RUN) ||
                   (st_next == pss_pkg::PSS_HOLD);
        // Direction and acc/dec set from stage code
        {rev_next, acc_next} = mode_of(out_idx);
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            st_reg <= pss_pkg::PSS_IDLE;
            idx_reg <= 4'h0;
            hold_reg <= 4'h0;
            el_reg <= 16'h0;
            pre_reg <= 32'h0;
            min_reg <= 6'h0;
            run_reg <= 1'b0;
            rev_reg <= 1'b0;
            acc_reg <= 2'h0;
            done_reg <= 1'b0;
            stage_index_out <= 4'h0;
        end else begin
            st_reg <= st_next;
            idx_reg <= idx_next;
            hold_reg <= hold_next;
            el_reg <= el_next;
            pre_reg <= pre_next;
            min_reg <= min_next;
            run_reg <= run_next;
            rev_reg <= rev_next;
            acc_reg <= acc_next;
            done_reg <= done_next;
            stage_index_out <= out_idx;
        end
    end

    assign run_out = run_reg;
    assign reverse_out = rev_reg;
    assign acc_set_out = acc_reg;
    assign stage_end_out = se_if.active;
    assign cycle_end_out = ce_if.active;

    property p_stage_adv;
        @(posedge mclk_in) disable iff (rst_in)
        (st_reg == pss_pkg::PSS_RUN && run_cmd_in && stage_done && !last_stage)
        |=> (idx_reg == $past(idx_reg) + 4'h1) && (el_reg == 16'h0);
    endproperty
    a_stage_adv: assert property (p_stage_adv) else $error("No advance");

    property p_single_stop;
        @(posedge mclk_in) disable iff (rst_in)
        (st_reg == pss_pkg::PSS_RUN && run_cmd_in && stage_done && last_stage
         && cycle_mode_select_in == pss_pkg::CYC_SINGLE)
        |=> !run_out ##1 !run_out;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("No stop");

    property p_cont_wrap;
        @(posedge mclk_in) disable iff (rst_in)
        (st_reg == pss_pkg::PSS_RUN && run_cmd_in && stage_done && last_stage
         && cycle_mode_select_in == pss_pkg::CYC_CONT)
        |=> idx_reg == 4'h0 && st_reg == pss_pkg::PSS_RUN;
    endproperty
    a_cont_wrap: assert property (p_cont_wrap) else $error("No wrap");

    property p_hold;
        @(posedge mclk_in) disable iff (rst_in)
        st_reg == pss_pkg::PSS_HOLD |-> stage_index_out == hold_reg;
    endproperty
    a_hold: assert property (p_hold) else $error("Hold index");

    property p_dir;
        @(posedge mclk_in) disable iff (rst_in)
        {reverse_out, acc_set_out} ==
            stage_run_mode_set_in[stage_index_out*3 +: 3];
    endproperty
    a_dir: assert property (p_dir) else $error("Mode code");

    property p_norec;
        @(posedge mclk_in) disable iff (rst_in)
        (st_reg == pss_pkg::PSS_RUN && !run_cmd_in
         && record_mode_in == pss_pkg::REC_OFF) |=> idx_reg == 4'h0;
    endproperty
    a_norec: assert property (p_norec) else $error("Progress kept");

    property p_rec;
        @(posedge mclk_in) disable iff (rst_in)
        (st_reg == pss_pkg::PSS_RUN && !run_cmd_in
         && record_mode_in != pss_pkg::REC_OFF)
        |=> st_reg == pss_pkg::PSS_PAUSE && $stable(idx_reg);
    endproperty
    a_rec: assert property (p_rec) else $error("No pause");

    property p_clear;
        @(posedge mclk_in) disable iff (rst_in)
        (st_reg == pss_pkg::PSS_PAUSE && cycle_mode_write_in)
        |=> idx_reg == 4'h0 && el_reg == 16'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("Not cleared");

    property p_se;
        @(posedge mclk_in) disable iff (rst_in)
        se_if.fire |=> stage_end_out;
    endproperty
    a_se: assert property (p_se) else $error("No stage pulse");

    property p_ce;
        @(posedge mclk_in) disable iff (rst_in)
        ce_if.fire |=> cycle_end_out;
    endproperty
    a_ce: assert property (p_ce) else $error("No cycle pulse");

    property p_tick;
        @(posedge mclk_in) disable iff (rst_in)
        (tick && st_reg == pss_pkg::PSS_RUN && run_cmd_in && !stage_done)
        |=> el_reg == $past(el_reg) + 16'h1;
    endproperty
    a_tick: assert property (p_tick) else $error("No count");

    c_wrap: cover property (@(posedge mclk_in) disable iff (rst_in)
        ce_if.fire && cycle_mode_select_in == pss_pkg::CYC_CONT);
    c_hold: cover property (@(posedge mclk_in) disable iff (rst_in)
        st_reg == pss_pkg::PSS_HOLD);
    c_pause: cover property (@(posedge mclk_in) disable iff (rst_in)
        st_reg == pss_pkg::PSS_PAUSE ##1 st_reg == pss_pkg::PSS_RUN);
endmodule : pss_sequencer

// ===== verification/pss_drive_model.sv
`timescale 1ns/10ps
module pss_drive_model (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Operator request
    input wire logic start_in,
    // Sequencer side
    input wire logic run_in,
    input wire logic reverse_in,
    output logic run_cmd_out,
    output logic [7:0] ramp_out
);
    logic [7:0] ramp_next;
    // Ramp follows run and direction
    always_comb begin
        ramp_next = 8'h00;
        if (run_in) begin
            ramp_next = reverse_in ? ramp_out - 8'h01 : ramp_out + 8'h01;
        end
    end
    // Run command level from operator
    always_ff @(posedge mclk_in) begin
        run_cmd_out <= rst_in ? 1'b0 : start_in;
        ramp_out <= rst_in ? 8'h00 : ramp_next;
    end
endmodule : pss_drive_model

// ===== verification/pss_sequencer_tb.sv
`timescale 1ns/10ps
module pss_sequencer_tb;
    localparam int T = 4;
    localparam int PL = 3;
    localparam int LIMIT = 10000;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [1:0] mode = 2'h0;
    logic wr = 1'b0;
    logic unit = 1'b0;
    logic [1:0] rec = 2'h0;
    logic [239:0] dur = '0;
    logic [44:0] rmode = '0;
    logic [14:0] fnz = '0;
    logic start = 1'b0;
    logic run_cmd, run, rev, se, ce, run_d, se_d, ce_d, pend;
    logic [3:0] idx, idx_d, idx_p, prv;
    logic [1:0] acc;
    logic [3:0] q[$];
    int n_fail = 0, compares = 0, cyc = 0, len = 0, sw = 0, cw = 0;
    int n_se = 0, n_ce = 0, h = 0, skip = 0;
    always #5 mclk_in = ~mclk_in;
    pss_drive_model u_drv (.mclk_in(mclk_in), .rst_in(rst_in),
        .start_in(start), .run_in(run), .reverse_in(rev),
        .run_cmd_out(run_cmd), .ramp_out());
    pss_sequencer #(.TENTH_CYC(T), .PULSE_LEN(PL)) u_dut (
        .mclk_in(mclk_in), .rst_in(rst_in), .cycle_mode_select_in(mode),
        .cycle_mode_write_in(wr), .stage_time_unit_in(unit),
        .record_mode_in(rec), .stage_duration_set_in(dur),
        .stage_run_mode_set_in(rmode), .stage_freq_nonzero_in(fnz),
        .run_cmd_in(run_cmd), .run_out(run), .stage_index_out(idx),
        .reverse_out(rev), .acc_set_out(acc), .stage_end_out(se),
        .cycle_end_out(ce));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic note(input logic [3:0] got);
        logic [3:0] e;
        int x;
        e = (q.size() > 0) ? q.pop_front() : 4'hX;
        x = int'(dur[int'(prv)*16+:16]) * T * (unit ? 60 : 1);
        check(16'(got), 16'(e));
        check(16'({rev, acc}), 16'(rmode[int'(got)*3+:3]));
        if (skip == 0) check(16'(len >= x - 2 && len <= x + 2), 16'h0001);
        else skip--;
        len = 0;
        prv = got;
    endtask : note
    task automatic go(input int a, input int b);
        for (int i = a; i <= b; i++) q.push_back(4'(i));
    endtask : go
    task automatic drain();
        start = 1'b1;
        for (int i = 0; i < 3000 && q.size() > 0; i++) @(posedge mclk_in);
        check(16'(q.size()), 16'h0000);
        @(negedge mclk_in);
    endtask : drain
    task automatic halt(input logic clr);
        start = 1'b0;
        repeat (10) @(negedge mclk_in);
        wr = clr;
        @(negedge mclk_in);
        wr = 1'b0;
    endtask : halt
    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    // Output watcher
    always @(negedge mclk_in) begin
        if (!rst_in) begin
            len++;
            if (run && !run_d) begin
                // Resumed stage is partial, not timed
                skip = (rec != pss_pkg::REC_OFF && idx != 4'h0) ? 2 : 1;
                note(idx);
            end
            if (pend && run) note(idx_p);
            pend = run && run_d && (idx !== idx_d);
            idx_p = idx;
            if (!se && se_d) check(16'(sw), 16'(PL));
            if (!ce && ce_d) check(16'(cw), 16'(PL));
            if (se && !se_d) n_se++;
            if (ce && !ce_d) n_ce++;
            sw = se ? sw + 1 : 0;
            cw = ce ? cw + 1 : 0;
        end
        run_d = run;
        idx_d = idx;
        se_d = se;
        ce_d = ce;
    end
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        void'($urandom(32'hA655AC9E));
        for (int i = 0; i < 15; i++) begin
            dur[i*16+:16] = 16'($urandom_range(3, 1));
            rmode[i*3+:3] = (i < 8) ? 3'(i) : 3'($urandom);
        end
        repeat (8) @(negedge mclk_in);
        rst_in = 1'b0;
        // Single cycle, stays stopped
        go(0, 14);
        drain();
        repeat (60) @(negedge mclk_in);
        check(16'(run), 16'h0000);
        check(16'(n_se), 16'h000F);
        check(16'(n_ce), 16'h0001);
        // Continuous wrap, stop restarts
        mode = pss_pkg::CYC_CONT;
        halt(1'b1);
        go(0, 14);
        go(0, 2);
        drain();
        halt(1'b0);
        go(0, 0);
        drain();
        // Breakpoint resume, cleared by rewrite
        for (int r = 1; r <= 2; r++) begin
            rec = 2'(r);
            halt(1'b1);
            go(0, 2);
            drain();
            halt(1'b0);
            go(2, 3);
            drain();
            halt(1'b1);
            go(0, 0);
            drain();
        end
        // Hold last nonzero stage
        mode = pss_pkg::CYC_HOLD;
        rec = pss_pkg::REC_OFF;
        fnz = (15'($urandom) & 15'h1FFF) | 15'h0002;
        for (int i = 0; i < 15; i++) if (fnz[i]) h = i;
        halt(1'b1);
        go(0, 14);
        go(h, h);
        drain();
        repeat (100) @(negedge mclk_in);
        check(16'(run), 16'h0001);
        check(16'(idx), 16'(h));
        // Minute base
        mode = pss_pkg::CYC_CONT;
        unit = pss_pkg::UNIT_MIN;
        dur[47:0] = {3{16'h0001}};
        halt(1'b1);
        go(0, 2);
        drain();
        start = 1'b0;
        summarize();
    end
endmodule : pss_sequencer_tb
